// ===== hw/pipe_stall_ctrl.sv
// Four-stage pipeline stall controller for fetch-incomplete and execute-only conflicts.
//
// Notes on behaviour
// RL1: A fetch lasting over one cycle holds the fetch stage until memory is ready.
// RL2: During a held fetch, decode gets a bubble; later stages keep advancing.
// RL3: A fetch crossing a bank boundary adds one wait state to the fetch.
// RL4: A store followed immediately by a dual-read instruction is an execute-only conflict.
// RL5: A two-store instruction followed by any read is an execute-only conflict.
// RL6: With three accesses needed, only execute advances; earlier stages freeze.
// RL7: After a single store, both reads of the next instruction wait one cycle.
// RL8: After a parallel store, the next data read waits one cycle.
// RL9: During an execute-only stall the same pending instruction is refetched.
// RL10: An interlocked load with the acknowledge flag high raises an execute-only stall.
// RL11: An interlocked load extends its read while the flag is 1, completes at 0.
`timescale 1ns/1ps
module pipe_stall_ctrl
  import stall_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            fetch_ready,
  input  wire logic            fetch_bank_cross,
  input  wire logic [1:0]      fetch_stores,
  input  wire logic [1:0]      fetch_reads,
  input  wire logic            fetch_ilock,
  input  wire logic            interlock_ack_flag,
  output logic [PC_W-1:0]      fetch_pc_r,
  output logic                 dec_valid_r,
  output logic                 rd_valid_r,
  output logic                 ex_valid_r,
  output logic [PC_W-1:0]      ex_pc_r,
  output logic                 fetch_hold_r,
  output logic                 read_defer_r,
  output logic                 refetch_r,
  output logic                 load_wait_r
);

  // ---------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------
  if (PC_W < 2 || PC_W > 32) begin : g_bad_pc_w
    $error("pipe_stall_ctrl: PC_W must lie between 2 and 32");
  end

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  instr_t            dec_r,    dec_nxt;
  instr_t            rd_r,     rd_nxt;
  instr_t            ex_r,     ex_nxt;
  logic [PC_W-1:0]   dec_pc_r, dec_pc_nxt;
  logic [PC_W-1:0]   rd_pc_r,  rd_pc_nxt;
  logic [PC_W-1:0]   ex_pc_nxt;
  logic [PC_W-1:0]   pc_nxt;
  fetch_st_t         fst_r,    fst_nxt;
  logic              deferred_r, deferred_nxt;
  logic              hold_nxt, defer_nxt, refetch_nxt, wait_nxt;
  logic              ack_level;
  logic              fetch_done;
  logic              freeze;
  instr_t            fetched;

  conflict_if cif ();

  ack_sync u_ack_sync (
    .clock   (clock),
    .rst     (rst),
    .pin     (interlock_ack_flag),
    .level_r (ack_level)
  );

  conflict_detect u_detect (
    .cif (cif.det)
  );

  assign cif.rd_ins    = rd_r;
  assign cif.ex_ins    = ex_r;
  assign cif.deferred  = deferred_r;
  assign cif.ack_level = ack_level;

  // ---------------------------------------------------------------------
  // Fetch stage
  // ---------------------------------------------------------------------
  always_comb begin
    freeze  = cif.ilock_wait || cif.mem_conflict;
    fetched = '{valid: 1'b1, stores: fetch_stores, reads: fetch_reads, ilock: fetch_ilock};
    // The first cycle of a bank-crossing fetch never completes.
    fetch_done = fetch_ready && !(fetch_bank_cross && fst_r == F_RUN); // RL3
    fst_nxt    = fst_r;
    unique case (fst_r)
      F_RUN: begin
        if (fetch_bank_cross && !freeze) begin
          fst_nxt = F_XTRA; // RL3
        end
      end
      F_XTRA: begin
        if (fetch_done || freeze) begin
          fst_nxt = F_RUN;
        end
      end
    endcase
    // A fetch that lands during a freeze is dropped and the same address is
    // fetched again, so nothing needs a holding buffer.
    pc_nxt = fetch_pc_r;
    if (fetch_done && !freeze) begin
      pc_nxt = fetch_pc_r + PC_W'(PC_STEP); // RL1 RL9
    end
  end

  // ---------------------------------------------------------------------
  // Stage advance
  // ---------------------------------------------------------------------
  always_comb begin
    dec_nxt      = dec_r;
    rd_nxt       = rd_r;
    ex_nxt       = ex_r;
    dec_pc_nxt   = dec_pc_r;
    rd_pc_nxt    = rd_pc_r;
    ex_pc_nxt    = ex_pc_r;
    deferred_nxt = 1'b0;
    if (cif.ilock_wait) begin
      // The load stays in execute with its read extended.
      deferred_nxt = deferred_r; // RL11
    end else if (cif.mem_conflict) begin
      // Store retires; the reader and everything behind it wait one cycle.
      ex_nxt       = BUBBLE; // RL6 RL7 RL8
      deferred_nxt = 1'b1;   // RL7 RL8
    end else begin
      ex_nxt     = rd_r;
      ex_pc_nxt  = rd_pc_r;
      rd_nxt     = dec_r;
      rd_pc_nxt  = dec_pc_r;
      dec_nxt    = fetch_done ? fetched : BUBBLE; // RL2
      dec_pc_nxt = fetch_pc_r;
    end
    hold_nxt    = !fetch_done && !freeze; // RL1
    defer_nxt   = cif.mem_conflict;
    refetch_nxt = freeze;                 // RL9
    wait_nxt    = cif.ilock_wait;         // RL10
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dec_r        <= BUBBLE;
      rd_r         <= BUBBLE;
      ex_r         <= BUBBLE;
      dec_pc_r     <= '0;
      rd_pc_r      <= '0;
      ex_pc_r      <= '0;
      fetch_pc_r   <= '0;
      fst_r        <= F_RUN;
      deferred_r   <= 1'b0;
      fetch_hold_r <= 1'b0;
      read_defer_r <= 1'b0;
      refetch_r    <= 1'b0;
      load_wait_r  <= 1'b0;
    end else begin
      dec_r        <= dec_nxt;
      rd_r         <= rd_nxt;
      ex_r         <= ex_nxt;
      dec_pc_r     <= dec_pc_nxt;
      rd_pc_r      <= rd_pc_nxt;
      ex_pc_r      <= ex_pc_nxt;
      fetch_pc_r   <= pc_nxt;
      fst_r        <= fst_nxt;
      deferred_r   <= deferred_nxt;
      fetch_hold_r <= hold_nxt;
      read_defer_r <= defer_nxt;
      refetch_r    <= refetch_nxt;
      load_wait_r  <= wait_nxt;
    end
  end

  assign dec_valid_r = dec_r.valid;
  assign rd_valid_r  = rd_r.valid;
  assign ex_valid_r  = ex_r.valid;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_fetch_pc_hold: assert property (!fetch_done && !freeze |=> $stable(fetch_pc_r)) // RL1
    else $error("fetch address moved while fetch incomplete");
  a_decode_bubble: assert property (!fetch_done && !freeze |=> !dec_valid_r && fetch_hold_r
                                    && ex_r == $past(rd_r)) // RL2
    else $error("held fetch did not bubble decode");
  a_bank_extra_wait: assert property (fst_r == F_RUN && fetch_bank_cross && !freeze
                                      |=> $stable(fetch_pc_r) && fst_r == F_XTRA) // RL3
    else $error("bank crossing fetch lacked a wait state");
  a_store_dual_read: assert property (ex_r.valid && rd_r.valid && ex_r.stores == CNT_ONE
                                      && rd_r.reads == CNT_TWO && !deferred_r && !cif.ilock_wait
                                      |-> cif.mem_conflict) // RL4
    else $error("store then dual read not detected");
  a_pair_store_read: assert property (ex_r.valid && rd_r.valid && ex_r.stores == CNT_TWO
                                      && rd_r.reads != CNT_NONE && !deferred_r
                                      && !cif.ilock_wait |-> cif.mem_conflict) // RL5
    else $error("parallel store then read not detected");
  a_only_exec_moves: assert property (cif.mem_conflict |=> !ex_r.valid && $stable(rd_r)
                                      && $stable(dec_r) && read_defer_r) // RL6
    else $error("earlier stages moved during execute-only conflict");
  a_defer_one_cycle: assert property (cif.mem_conflict |=> !cif.mem_conflict
                                      ##1 (ex_r == $past(rd_r, 2) || $past(cif.ilock_wait))) // RL7
    else $error("reads not postponed by exactly one cycle");
  a_pair_read_wait: assert property (cif.mem_conflict && ex_r.stores == CNT_TWO
                                     |=> rd_r == $past(rd_r) ##1 !read_defer_r) // RL8
    else $error("read after parallel store did not wait once");
  a_refetch_same: assert property (freeze |=> $stable(fetch_pc_r) && refetch_r) // RL9
    else $error("refetch did not repeat the pending instruction");
  a_ilock_raise: assert property (ex_r.valid && ex_r.ilock && ack_level
                                  |-> cif.ilock_wait ##1 load_wait_r) // RL10
    else $error("interlocked load ignored high acknowledge flag");
  a_ilock_release: assert property (cif.ilock_wait |=> $stable(ex_pc_r) && ex_r == $past(ex_r)
                                    && load_wait_r) // RL11
    else $error("interlocked load released while flag high");
  a_ilock_complete: assert property (cif.ilock_wait ##1 !ack_level
                                     |=> !ex_r.valid || ex_r == $past(rd_r)) // RL11
    else $error("interlocked load held after flag went low");

  c_fetch_wait:  cover property (!fetch_done ##1 fetch_done);
  c_store_read:  cover property (cif.mem_conflict ##2 ex_r.valid);
  c_ilock_spin:  cover property (cif.ilock_wait [*3] ##1 !cif.ilock_wait);
  c_bank_cross:  cover property (fst_r == F_XTRA ##1 fetch_done);

endmodule : pipe_stall_ctrl

// ===== hw/stall_pkg.sv
// Shared constants and types for the pipeline memory-conflict stall logic.
package stall_pkg;

  // ---------------------------------------------------------------------
  // Access counts carried with each instruction, plus sync depth, acknowledge reset and fetch step
  // ---------------------------------------------------------------------
  localparam int          CNT_W      = 2;
  localparam logic [1:0]  CNT_NONE   = 2'h0;
  localparam logic [1:0]  CNT_ONE    = 2'h1;
  localparam logic [1:0]  CNT_TWO    = 2'h2;
  localparam int          SYNC_DEPTH = 3;
  localparam logic        ACK_RST    = 1'b0;
  localparam int          PC_STEP    = 1;

  typedef struct packed {
    logic             valid;
    logic [CNT_W-1:0] stores;
    logic [CNT_W-1:0] reads;
    logic             ilock;
  } instr_t;

  localparam instr_t BUBBLE = '{valid: 1'b0, stores: CNT_NONE, reads: CNT_NONE, ilock: 1'b0};

  // ---------------------------------------------------------------------
  // Fetch sequencing, Gray coded
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    F_RUN  = 2'b00,
    F_XTRA = 2'b01
  } fetch_st_t;

endpackage : stall_pkg

// ===== hw/conflict_if.sv
// Carrier between the stall controller and its conflict detector.
`timescale 1ns/1ps
interface conflict_if;
  import stall_pkg::*;
  instr_t rd_ins;
  instr_t ex_ins;
  logic   deferred;
  logic   ack_level;
  logic   mem_conflict;
  logic   ilock_wait;

  modport det (
    input  rd_ins,
    input  ex_ins,
    input  deferred,
    input  ack_level,
    output mem_conflict,
    output ilock_wait
  );
  modport ctl (
    output rd_ins,
    output ex_ins,
    output deferred,
    output ack_level,
    input  mem_conflict,
    input  ilock_wait
  );
endinterface : conflict_if

// ===== hw/ack_sync.sv
// Three-stage synchroniser with agreement filter for the acknowledge pin.
`timescale 1ns/1ps
module ack_sync
  import stall_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level_r
);
  logic [SYNC_DEPTH-1:0] sh_r;
  logic [SYNC_DEPTH-1:0] sh_nxt;
  logic                  level_nxt;

  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb begin
    sh_nxt    = {sh_r[SYNC_DEPTH-2:0], pin};
    level_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : level_r;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_r    <= '0;
      level_r <= ACK_RST;
    end else begin
      sh_r    <= sh_nxt;
      level_r <= level_nxt;
    end
  end
endmodule : ack_sync

// ===== hw/conflict_detect.sv
// Detects execute-only conflicts between the read and execute stages.
`timescale 1ns/1ps
module conflict_detect
  import stall_pkg::*;
(
  conflict_if.det cif
);
  logic store_dual;
  logic pair_any;

  always_comb begin
    // Three data accesses in one cycle exceed the two that memory offers.
    store_dual = cif.ex_ins.stores == CNT_ONE && cif.rd_ins.reads == CNT_TWO;  // RL4
    pair_any   = cif.ex_ins.stores == CNT_TWO && cif.rd_ins.reads != CNT_NONE; // RL5
    cif.ilock_wait   = cif.ex_ins.valid && cif.ex_ins.ilock && cif.ack_level;    // RL10
    cif.mem_conflict = cif.ex_ins.valid && cif.rd_ins.valid && !cif.deferred
                       && !cif.ilock_wait && (store_dual || pair_any);
  end
endmodule : conflict_detect

// ===== sim/mem_ack_model.sv
// Wait-state program memory and interlock acknowledge source facing the stall controller.
`timescale 1ns/1ps
module mem_ack_model #(
  parameter int PC_W = 16
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic [PC_W-1:0] fetch_pc,
  input  wire logic [1:0]      waits,
  input  wire logic            release_ack,
  output logic                 ready,
  output logic                 bank_cross,
  output logic [1:0]           stores,
  output logic [1:0]           reads,
  output logic                 ilock,
  output logic                 ack
);
  logic [PC_W-1:0] prev_r;
  logic [1:0]      cnt_r;
  logic [1:0]      w;
  logic            fresh;

  assign w     = (fetch_pc == 20) ? waits : 2'h0;
  assign fresh = (fetch_pc != prev_r);
  // A new address pays its wait states; a repeated address is answered once the wait count reaches zero.
  assign ready      = fresh ? (w == 2'h0) : (cnt_r == 2'h0);
  assign bank_cross = (fetch_pc == 24);
  // Fields mean nothing without ready, so they show a changing pattern then.
  assign stores = !ready ? ~prev_r[1:0] : (fetch_pc == 4) ? 2'h1 : (fetch_pc == 8) ? 2'h2 : 2'h0;
  assign reads  = !ready ? prev_r[1:0] : (fetch_pc == 5) ? 2'h2 : (fetch_pc == 9) ? 2'h1 : 2'h0;
  assign ilock  = ready ? (fetch_pc == 12) : prev_r[0];
  // The far party holds the flag high until it lets the read finish.
  assign ack = !release_ack;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_r <= '0;
      cnt_r  <= 2'h0;
    end else begin
      prev_r <= fetch_pc;
      if (fresh) begin
        cnt_r <= (w == 2'h0) ? 2'h0 : w - 2'h1;
      end else if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule : mem_ack_model

// ===== sim/pipeline_memory_conflict_stall_tb.sv
// Self-checking testbench for the pipeline memory-conflict stall controller.
`timescale 1ns/1ps
module pipeline_memory_conflict_stall_tb;
  localparam int PC_W = 16;
  localparam int LAST = 30;
  logic            clock, rst, fetch_ready, fetch_bank_cross, fetch_ilock, ack, release_ack;
  logic [1:0]      fetch_stores, fetch_reads, waits;
  logic [PC_W-1:0] fetch_pc_r, ex_pc_r, pc_prev;
  logic            dec_valid_r, rd_valid_r, ex_valid_r, fetch_hold_r;
  logic            read_defer_r, refetch_r, load_wait_r;
  int              num_errors, n_checks, seed, k, last_ex;
  int              n_hold, n_defer, n_refetch, n_wait;
  int              exp_q[$];

  pipe_stall_ctrl #(.PC_W(PC_W)) u_pipe_stall_ctrl (
    .clock(clock), .rst(rst), .fetch_ready(fetch_ready), .fetch_bank_cross(fetch_bank_cross),
    .fetch_stores(fetch_stores), .fetch_reads(fetch_reads), .fetch_ilock(fetch_ilock),
    .interlock_ack_flag(ack), .fetch_pc_r(fetch_pc_r), .dec_valid_r(dec_valid_r),
    .rd_valid_r(rd_valid_r), .ex_valid_r(ex_valid_r), .ex_pc_r(ex_pc_r),
    .fetch_hold_r(fetch_hold_r), .read_defer_r(read_defer_r), .refetch_r(refetch_r),
    .load_wait_r(load_wait_r));

  mem_ack_model #(.PC_W(PC_W)) u_mem_ack_model (
    .clock(clock), .rst(rst), .fetch_pc(fetch_pc_r), .waits(waits),
    .release_ack(release_ack), .ready(fetch_ready), .bank_cross(fetch_bank_cross),
    .stores(fetch_stores), .reads(fetch_reads), .ilock(fetch_ilock), .ack(ack));

  task automatic check(input string what, input int exp, input logic [31:0] got);
    n_checks++;
    if (got !== 32'(exp)) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------------
  // Clock, watchdog and per-cycle monitor
  // ---------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (2000) @(posedge clock);
    num_errors++;
    give_verdict();
  end

  // An instruction held in execute by the interlock must not count as a new one.
  always @(posedge clock) begin
    #2;
    if (rst === 1'b0) begin
      if (ex_valid_r === 1'b1 && load_wait_r !== 1'b1) begin
        last_ex = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
        check("ex_pc", last_ex, ex_pc_r);
      end
      if (fetch_hold_r === 1'b1) begin
        n_hold++;
        check("dec_bubble", 0, dec_valid_r);
      end
      if (read_defer_r === 1'b1) begin
        n_defer++;
        check("ex_bubble", 0, ex_valid_r);
        check("rd_held", 1, rd_valid_r);
      end
      if (read_defer_r === 1'b1 || refetch_r === 1'b1) begin
        check("frozen_pc", int'(pc_prev), fetch_pc_r);
      end
      if (refetch_r === 1'b1) n_refetch++;
      if (load_wait_r === 1'b1) begin
        n_wait++;
        check("wait_pc", 12, ex_pc_r);
      end
    end
    pc_prev = fetch_pc_r;
  end

  // ---------------------------------------------------------------------
  // Main sequence: one program run three times with random wait states and flag timing
  // ---------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    waits = 2'h0;
    release_ack = 1'b0;
    seed = 29;
    num_errors = 0;
    n_checks = 0;
    for (int r = 0; r < 3; r++) begin
      rst = 1'b1;
      repeat (10) @(posedge clock);
      #1;
      waits = 2'($random(seed));
      k = 1 + ($random(seed) & 3);
      release_ack = 1'b0;
      exp_q.delete();
      for (int i = 0; i <= LAST; i++) exp_q.push_back(i);
      {n_hold, n_defer, n_refetch, n_wait} = '0;
      last_ex = -1;
      rst = 1'b0;
      for (int c = 0; c < 200 && last_ex != LAST; c++) begin
        @(posedge clock);
        #1;
        if (n_wait >= k) release_ack = 1'b1;
      end
      check("last_ex", LAST, last_ex);
      check("holds", int'(waits) + 1, n_hold);
      check("defers", 2, n_defer);
      check("refetches", n_defer + n_wait, n_refetch);
      // The release lags the count by one bench cycle, and the pin filter needs four edges.
      check("wait_span", k + 5, n_wait);
    end
    give_verdict();
  end
endmodule : pipeline_memory_conflict_stall_tb
